/* File: rtl/ddc_bind_params.svh */
// register offsets, resets and field positions for the channel binding block
`ifndef DDC_BIND_PARAMS_SVH
`define DDC_BIND_PARAMS_SVH
// printed offsets are not multiples of four: they are word indices
`define IDX_SRC_SEL 12'h0216
`define IDX_REF_DIV 12'h0217
`define IDX_SYNC_CTL 12'h0219
`define IDX_LINK_CTL 12'h021A
`define RST_SRC_SEL 8'h02
`define RST_REF_DIV 16'h0000
`define RST_SYNC_CTL 8'h02
`define RST_LINK_CTL 8'h00
`define BIT_SEL_A 0
`define BIT_SEL_B 1
`define BIT_INIT_NEXT 0
`define BIT_INIT_SYNC 1
`define BIT_LINK_EN 0
`define BIT_CAL_EN 1
`define BIT_PD_A 2
`define BIT_PD_B 3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: rtl/ddc_bind_pkg.sv */
// types shared by the channel binding block
package ddc_bind_pkg;
    // one adc sample word pair, one lane per channel
    typedef struct packed {
        logic [15:0] chA;
        logic [15:0] chB;
    } sample_pair_t;

    // arming states of the next-sysref phase init
    typedef enum logic [1:0] {
        ARM_IDLE,
        ARM_CLEARED,
        ARM_ARMED
    } arm_state_t;
endpackage

/* File: rtl/ddc_channel_binding.sv */
// channel binding, reference divisor and nco phase sync control with an axi4-lite slave
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ddc_bind_params.svh"
module ddc_channel_binding #(
    parameter int SAMPLE_W = 16,
    parameter int ADDR_W = 14
) (
    input wire logic clk_sys, // 50 MHz system clock
    input wire logic rst, // async reset, active high
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire ddc_bind_pkg::sample_pair_t adcIn, // samples from adc A and B cores
    output ddc_bind_pkg::sample_pair_t digOut, // samples to digital channels A and B
    input wire logic syncRelease, // sync~ released (high = deasserted)
    input wire logic frameBoundary, // lmfc/lemc boundary pulse
    input wire logic sysref, // sysref level
    output logic ncoPhaseInit, // one-cycle nco phase init pulse
    output logic [15:0] referenceDivisor, // divisor shared by all presets
    output logic divisorEnable, // divisor nonzero
    output logic [1:0] digPowerDown, // power down digital channel A(0) B(1)
    output logic [1:0] linkPowerDown, // power down link of channel A(0) B(1)
    output logic serialLinkEnable, // link enable to the serial interface
    output logic calibrationEnable // calibration enable
);
    // =====================================================================
    // elaboration checks
    generate
        if (SAMPLE_W != 16 || ADDR_W < 14) begin : g_badParam
            $error("ddc_channel_binding: unsupported parameter values");
        end
    endgenerate

    // =====================================================================
    // state
    typedef struct packed {
        logic awHeld;
        logic [ADDR_W-1:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic [7:0] srcSel;
        logic [15:0] refDiv;
        logic divEn;
        logic [7:0] syncCtl;
        logic [7:0] linkCtl;
        ddc_bind_pkg::arm_state_t armState;
        logic syncPrev;
        logic syncPending;
        logic sysrefPrev;
        logic initPulse;
        ddc_bind_pkg::sample_pair_t dig;
        logic [1:0] digPd;
    } state_t;

    state_t cur_ff;
    state_t nxt_cur;

    logic [ADDR_W-3:0] wIdx;
    logic [ADDR_W-3:0] rIdx;
    logic doWrite;
    logic wMapped;
    logic [31:0] rWord;
    logic rMapped;
    logic [7:0] newSync;
    logic selA;
    logic selB;
    logic pdA;
    logic pdB;

    // =====================================================================
    // bus decode; word index is byte address over four
    always_comb begin
        wIdx = cur_ff.awAddr[ADDR_W-1:2];
        rIdx = s_axi_araddr[ADDR_W-1:2];
        doWrite = cur_ff.awHeld && cur_ff.wHeld && !cur_ff.bValid;
        wMapped = (wIdx == (ADDR_W-2)'(`IDX_SRC_SEL)) || (wIdx == (ADDR_W-2)'(`IDX_REF_DIV))
            || (wIdx == (ADDR_W-2)'(`IDX_SYNC_CTL)) || (wIdx == (ADDR_W-2)'(`IDX_LINK_CTL));
        rMapped = 1'b1;
        unique case (1'b1)
            rIdx == (ADDR_W-2)'(`IDX_SRC_SEL): rWord = {24'h00_0000, cur_ff.srcSel};
            rIdx == (ADDR_W-2)'(`IDX_REF_DIV): rWord = {16'h0000, cur_ff.refDiv};
            rIdx == (ADDR_W-2)'(`IDX_SYNC_CTL): rWord = {24'h00_0000, cur_ff.syncCtl};
            rIdx == (ADDR_W-2)'(`IDX_LINK_CTL): rWord = {24'h00_0000, cur_ff.linkCtl};
            default: begin
                rWord = 32'h0000_0000;
                rMapped = 1'b0;
            end
        endcase
    end

    // =====================================================================
    // next state
    always_comb begin
        nxt_cur = cur_ff;
        newSync = cur_ff.syncCtl;
        // address and data channels are taken independently, in either order
        if (s_axi_awvalid && !cur_ff.awHeld) begin
            nxt_cur.awHeld = 1'b1;
            nxt_cur.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !cur_ff.wHeld) begin
            nxt_cur.wHeld = 1'b1;
            nxt_cur.wData = s_axi_wdata;
            nxt_cur.wStrb = s_axi_wstrb;
        end
        if (cur_ff.bValid && s_axi_bready) begin
            nxt_cur.bValid = 1'b0;
        end
        // registers are at most 16 bits wide, so only lanes 0 and 1 matter
        if (doWrite) begin
            nxt_cur.awHeld = 1'b0;
            nxt_cur.wHeld = 1'b0;
            nxt_cur.bValid = 1'b1;
            nxt_cur.bResp = wMapped ? `RESP_OKAY : `RESP_SLVERR;
            if (cur_ff.wStrb[0]) begin
                unique case (1'b1)
                    wIdx == (ADDR_W-2)'(`IDX_SRC_SEL): nxt_cur.srcSel = cur_ff.wData[7:0];
                    wIdx == (ADDR_W-2)'(`IDX_REF_DIV): nxt_cur.refDiv[7:0] = cur_ff.wData[7:0];
                    wIdx == (ADDR_W-2)'(`IDX_SYNC_CTL): newSync = cur_ff.wData[7:0];
                    wIdx == (ADDR_W-2)'(`IDX_LINK_CTL): nxt_cur.linkCtl = cur_ff.wData[7:0];
                    default: ;
                endcase
            end
            if (cur_ff.wStrb[1] && wIdx == (ADDR_W-2)'(`IDX_REF_DIV)) begin
                nxt_cur.refDiv[15:8] = cur_ff.wData[15:8];
            end
        end
        nxt_cur.syncCtl = newSync;
        // enable is kept in a flop beside the divisor so the output carries no gate
        nxt_cur.divEn = |nxt_cur.refDiv;
        // read: one answer at a time, held until rready
        if (cur_ff.rValid && s_axi_rready) begin
            nxt_cur.rValid = 1'b0;
        end
        if (s_axi_arvalid && !cur_ff.rValid) begin
            nxt_cur.rValid = 1'b1;
            nxt_cur.rData = rWord;
            nxt_cur.rResp = rMapped ? `RESP_OKAY : `RESP_SLVERR;
        end

        // arm only when init-next bit 0 is seen 0 and then 1; its reset value of 0 counts, so one write of 1 arms after reset
        nxt_cur.sysrefPrev = sysref;
        nxt_cur.initPulse = 1'b0;
        unique case (cur_ff.armState)
            ddc_bind_pkg::ARM_IDLE: begin
                if (!newSync[`BIT_INIT_NEXT]) begin
                    nxt_cur.armState = ddc_bind_pkg::ARM_CLEARED;
                end
            end
            ddc_bind_pkg::ARM_CLEARED: begin
                if (newSync[`BIT_INIT_NEXT]) begin
                    nxt_cur.armState = ddc_bind_pkg::ARM_ARMED;
                end
            end
            ddc_bind_pkg::ARM_ARMED: begin
                if (!newSync[`BIT_INIT_NEXT]) begin
                    nxt_cur.armState = ddc_bind_pkg::ARM_CLEARED;
                end else if (sysref && !cur_ff.sysrefPrev) begin
                    nxt_cur.armState = ddc_bind_pkg::ARM_IDLE;
                    nxt_cur.initPulse = 1'b1;
                end
            end
        endcase

        // sync rise waits for the next frame boundary
        nxt_cur.syncPrev = syncRelease;
        if (!cur_ff.syncCtl[`BIT_INIT_SYNC]) begin
            nxt_cur.syncPending = 1'b0;
        end else if (syncRelease && !cur_ff.syncPrev) begin
            nxt_cur.syncPending = 1'b1;
        end else if (cur_ff.syncPending && frameBoundary) begin
            nxt_cur.syncPending = 1'b0;
            nxt_cur.initPulse = 1'b1;
        end

        selA = cur_ff.srcSel[`BIT_SEL_A];
        selB = cur_ff.srcSel[`BIT_SEL_B];
        nxt_cur.dig.chA = selA ? adcIn.chB : adcIn.chA;
        nxt_cur.dig.chB = selB ? adcIn.chB : adcIn.chA;
        // power down follows the bound adc
        pdA = cur_ff.linkCtl[`BIT_PD_A];
        pdB = cur_ff.linkCtl[`BIT_PD_B];
        nxt_cur.digPd[0] = selA ? pdB : pdA;
        nxt_cur.digPd[1] = selB ? pdB : pdA;
    end

    // =====================================================================
    // state register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cur_ff <= '0;
            cur_ff.srcSel <= `RST_SRC_SEL;
            cur_ff.refDiv <= `RST_REF_DIV;
            cur_ff.divEn <= |`RST_REF_DIV;
            cur_ff.syncCtl <= `RST_SYNC_CTL;
            cur_ff.linkCtl <= `RST_LINK_CTL;
            cur_ff.armState <= ddc_bind_pkg::ARM_IDLE;
            cur_ff.digPd <= 2'h0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // =====================================================================
    // outputs, all straight from the state register
    always_comb begin
        s_axi_awready = !cur_ff.awHeld;
        s_axi_wready = !cur_ff.wHeld;
        s_axi_bvalid = cur_ff.bValid;
        s_axi_bresp = cur_ff.bResp;
        s_axi_arready = !cur_ff.rValid;
        s_axi_rvalid = cur_ff.rValid;
        s_axi_rdata = cur_ff.rData;
        s_axi_rresp = cur_ff.rResp;
        digOut = cur_ff.dig;
        ncoPhaseInit = cur_ff.initPulse;
        referenceDivisor = cur_ff.refDiv;
        divisorEnable = cur_ff.divEn;
        digPowerDown = cur_ff.digPd;
        linkPowerDown = cur_ff.digPd;
        serialLinkEnable = cur_ff.linkCtl[`BIT_LINK_EN];
        calibrationEnable = cur_ff.linkCtl[`BIT_CAL_EN];
    end

    // =====================================================================
    // assertions
    // channel B and A routing, power down and divisor
    AST_ROUTE_B: assert property (@(posedge clk_sys) disable iff (rst)
        !$past(rst) |-> digOut.chB == ($past(cur_ff.srcSel[1]) ? $past(adcIn.chB) : $past(adcIn.chA)))
        else $error("channel B routing wrong");
    AST_ROUTE_A: assert property (@(posedge clk_sys) disable iff (rst)
        !$past(rst) |-> digOut.chA == ($past(cur_ff.srcSel[0]) ? $past(adcIn.chB) : $past(adcIn.chA)))
        else $error("channel A routing wrong");
    AST_PD_A: assert property (@(posedge clk_sys) disable iff (rst)
        digPowerDown[0] == ($past(cur_ff.srcSel[0]) ? $past(cur_ff.linkCtl[3]) : $past(cur_ff.linkCtl[2])))
        else $error("channel A power down wrong");
    AST_PD_B: assert property (@(posedge clk_sys) disable iff (rst)
        digPowerDown[1] == ($past(cur_ff.srcSel[1]) ? $past(cur_ff.linkCtl[3]) : $past(cur_ff.linkCtl[2])))
        else $error("channel B power down wrong");
    AST_PD_LINK: assert property (@(posedge clk_sys) disable iff (rst)
        linkPowerDown == digPowerDown)
        else $error("link power down differs from channel");
    AST_DIV_EN: assert property (@(posedge clk_sys) disable iff (rst)
        divisorEnable == (referenceDivisor != 16'h0000))
        else $error("divisor enable wrong");
    AST_DIV_SHARED: assert property (@(posedge clk_sys) disable iff (rst)
        $changed(referenceDivisor) |-> $past(doWrite))
        else $error("divisor changed without a write");
    // sync init fires at the boundary
    AST_SYNC_INIT: assert property (@(posedge clk_sys) disable iff (rst)
        (cur_ff.syncPending && frameBoundary && cur_ff.syncCtl[1]) |=> ncoPhaseInit)
        else $error("missing init at boundary");
    // armed sysref edge fires once and disarms
    AST_SYSREF_ONCE: assert property (@(posedge clk_sys) disable iff (rst)
        (cur_ff.armState == ddc_bind_pkg::ARM_ARMED && sysref && !cur_ff.sysrefPrev && newSync[0])
        |=> ncoPhaseInit && cur_ff.armState == ddc_bind_pkg::ARM_IDLE)
        else $error("sysref init not taken once");
    // no init pulse without a cause
    AST_NO_SPURIOUS: assert property (@(posedge clk_sys) disable iff (rst)
        ncoPhaseInit |-> ($past(cur_ff.armState) == ddc_bind_pkg::ARM_ARMED || $past(cur_ff.syncPending)))
        else $error("spurious phase init");
endmodule // ddc_channel_binding
`default_nettype wire

/* File: tb/adc_core_model.sv */
// behavioural pair of adc channel cores feeding the binding block
`timescale 1ns/100ps
`default_nettype none
module adc_core_model (
    input wire logic clk_sys, // sample clock
    input wire logic rst, // async reset, active high
    output var ddc_bind_pkg::sample_pair_t samples // adc A and B words
);
    logic [15:0] count_ff;
    // fresh words every cycle, lanes differ, so a stale or swapped route shows
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) count_ff <= 16'h0000;
        else count_ff <= count_ff + 16'h0001;
    end
    assign samples = {4'hA, count_ff[11:0], 4'h5, ~count_ff[11:0]}; // chA then chB
endmodule // adc_core_model
`default_nettype wire

/* File: tb/test_ddc_channel_binding.sv */
// self-checking bench for the channel binding block
`timescale 1ns/100ps
`default_nettype none
`include "ddc_bind_params.svh"
module test_ddc_channel_binding;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdVal;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp, digPowerDown, linkPowerDown;
    logic syncRelease = 0, frameBoundary = 0, sysref = 0;
    logic ncoPhaseInit, divisorEnable, serialLinkEnable, calibrationEnable;
    logic [15:0] referenceDivisor, exA, exB;
    ddc_bind_pkg::sample_pair_t adcIn, digOut, prevIn;
    int fail_count = 0;
    int samples_checked = 0;
    int pulses = 0;
    int base;
    // rows: select[5:4], adc power downs[3:2], expected channel power downs[1:0]
    // last row leaves the default binding in place
    logic [5:0] rows [11] = '{6'h00, 6'h30, 6'h07, 6'h16, 6'h25, 6'h3B, 6'h08, 6'h19, 6'h2A, 6'h3F, 6'h20};

    adc_core_model adcs (.clk_sys, .rst, .samples(adcIn));
    ddc_channel_binding #(.SAMPLE_W(16), .ADDR_W(14)) uut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .adcIn, .digOut, .syncRelease, .frameBoundary, .sysref, .ncoPhaseInit, .referenceDivisor,
        .divisorEnable, .digPowerDown, .linkPowerDown, .serialLinkEnable, .calibrationEnable);

    always #10 clk_sys = ~clk_sys;
    // phase init is a one-cycle pulse, so counting edges counts events
    always @(posedge clk_sys) if (ncoPhaseInit === 1'b1) pulses <= pulses + 1;

    // ====================
    // bus and check tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    // address and data offered together, each dropped when its own ready is seen
    task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic [3:0] strb);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rc(input logic [11:0] idx, input logic [31:0] exp);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rdVal = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
        chk(rdVal, exp);
    endtask
    // one-cycle boundary (0) or sysref (1) pulse, then settle time
    task automatic strobe(input int which);
        if (which == 0) frameBoundary <= 1'b1;
        else sysref <= 1'b1;
        @(posedge clk_sys);
        frameBoundary <= 1'b0;
        sysref <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ====================
    // main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rc(`IDX_SRC_SEL, 32'h0000_0002);
        rc(`IDX_REF_DIV, 32'h0000_0000);
        rc(`IDX_SYNC_CTL, 32'h0000_0002);
        rc(`IDX_LINK_CTL, 32'h0000_0000);
        foreach (rows[i]) begin
            wr(`IDX_LINK_CTL, 32'h0000_0000, 4'h1);
            wr(`IDX_SRC_SEL, {30'h0, rows[i][5:4]}, 4'h1);
            chk(resp, `RESP_OKAY);
            wr(`IDX_LINK_CTL, {28'h0, rows[i][3:2], 2'b00}, 4'h1);
            rc(`IDX_SRC_SEL, {30'h0, rows[i][5:4]});
            prevIn = adcIn;
            #1;
            exA = rows[i][4] ? prevIn.chB : prevIn.chA;
            exB = rows[i][5] ? prevIn.chB : prevIn.chA;
            if (!rows[i][0]) chk(digOut.chA, exA);
            if (!rows[i][1]) chk(digOut.chB, exB);
            chk(digPowerDown, rows[i][1:0]);
            chk(linkPowerDown, rows[i][1:0]);
        end
        wr(`IDX_LINK_CTL, 32'h0000_0003, 4'h1);
        @(posedge clk_sys);
        chk({serialLinkEnable, calibrationEnable}, 2'b11);
        // divisor: boundary value, upper lane alone, then back to disabled
        // integer divisors, none above 8192; the register takes any 16-bit value
        wr(`IDX_REF_DIV, 32'h1234_2000, 4'hF);
        rc(`IDX_REF_DIV, 32'h0000_2000);
        chk({divisorEnable, referenceDivisor}, 17'h1_2000);
        wr(`IDX_REF_DIV, 32'h0000_10AA, 4'h2);
        rc(`IDX_REF_DIV, 32'h0000_1000);
        wr(`IDX_REF_DIV, 32'h0000_0000, 4'h3);
        @(posedge clk_sys);
        chk({divisorEnable, referenceDivisor}, 17'h0_0000);
        // unmapped place between divisor and sync control
        wr(12'h218, 32'h0000_00FF, 4'hF);
        chk(resp, `RESP_SLVERR);
        rc(12'h218, 32'h0000_0000);
        chk(resp, `RESP_SLVERR);
        // sync release then boundary gives one init; a lone boundary none
        base = pulses;
        syncRelease <= 1'b1;
        repeat (3) @(posedge clk_sys);
        strobe(0);
        chk(pulses - base, 1);
        strobe(0);
        strobe(1);
        chk(pulses - base, 1);
        // arm next sysref with 0 then 1; only the first edge counts
        wr(`IDX_SYNC_CTL, 32'h0000_0000, 4'h1);
        wr(`IDX_SYNC_CTL, 32'h0000_0001, 4'h1);
        strobe(1);
        strobe(1);
        chk(pulses - base, 2);
        syncRelease <= 1'b0;
        wr(`IDX_SYNC_CTL, 32'h0000_0000, 4'h1);
        syncRelease <= 1'b1;
        wr(`IDX_SYNC_CTL, 32'h0000_0001, 4'h1);
        strobe(0);
        chk(pulses - base, 2);
        strobe(1);
        chk(pulses - base, 3);
        // reset in mid-run restores defaults
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rc(`IDX_SYNC_CTL, 32'h0000_0002);
        rc(`IDX_SRC_SEL, 32'h0000_0002);
        end_sim();
    end

    // watchdog: the sequence needs well under a tenth of this span
    initial begin
        #400_000;
        fail_count++;
        end_sim();
    end
endmodule // test_ddc_channel_binding
`default_nettype wire
